// [core/rsc_pkg.sv]
`default_nettype none
package rsc_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 50;
    localparam int unsigned SUBCR_WAIT_NS  = 100000;
    localparam int unsigned MAINCR_WAIT_NS = 20000;
    localparam int unsigned FILT_NS        = 200;
    localparam int unsigned SUBCR_CYC      = (SUBCR_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MAINCR_CYC     = (MAINCR_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FILT_CYC       = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] SUBCR_LAST     = 16'(SUBCR_CYC - 1);
    localparam logic [15:0] MAINCR_LAST    = 16'(MAINCR_CYC - 1);
    localparam logic [7:0]  FILT_LAST      = 8'(FILT_CYC - 1);

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0]  ADDR_FLAGS     = 4'h0;
    localparam logic [3:0]  ADDR_CTRL      = 4'h4;
    localparam int unsigned CTRL_SOFT_BIT  = 0;
    localparam int unsigned CTRL_INEN_BIT  = 1;
    localparam int unsigned CTRL_OUTEN_BIT = 2;
    localparam logic        CTRL_INEN_RST  = 1'b1;
    localparam logic        CTRL_OUTEN_RST = 1'b1;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic pin_reset_flag;
        logic dog_reset_flag;
        logic powerup_reset_flag;
        logic hard_reset_flag;
        logic soft_reset_flag;
    } rsc_flags_t;

    typedef struct packed {
        logic ext;
        logic dog;
        logic pon;
        logic sw;
    } rsc_cause_t;

    localparam rsc_flags_t FLAGS_POR_RST = 5'h06;
    localparam rsc_cause_t CAUSE_POR     = 4'h2;

    typedef enum logic [2:0] {ST_RUN, ST_HOLD, ST_SUBW, ST_EXTW, ST_MAINW, ST_FETCH} rsc_state_t;

endpackage : rsc_pkg
`default_nettype wire

// [core/rsc_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Pin, soft and watchdog sources stop the CPU once no RAM access is in progress; release is followed by a mode fetch.
// - Power-on or slow/stop-mode release delays the fetch past the stabilization wait.
// - Five sources: pin low, soft request, watchdog, power-on, low voltage.
// - Pin passes a noise filter; internal reset is synchronous to the clock.
// - Pin logic is reset asynchronously, without the synchronous reset.
// - Low-voltage reset behaves like power-on reset, but keeps flag bits 3 and 4.
// - Soft, dog or pin reset with sub-CR ready, outside slow/stop mode, waits only the main wait.
// - Same sources with sub-CR not ready wait sub-CR then main wait.
// - Power-on and low-voltage always wait sub-CR then main wait.
// - Every mode fetch follows a finished main CR wait.
// - With input and output enabled, pin driven low for internal resets only.
// - Internal reset waits for a RAM access in progress to end, except on low-voltage or power-on reset.
// - Port pins stay high impedance until software configures them.
// - Upper unused flag bits read zero and ignore writes.
// - Bit 4 is set on a pin reset.
// - Other resets leave bit 4 unchanged, except power-on, which clears it.
// - Reading the flags clears them.
// - Any write to the flags clears them.
// - Bit 3 set on watchdog reset, cleared on power-on, kept otherwise.
// - Bit 2 set on power-on or low-voltage reset, kept otherwise.
// - Bit 1 set with any of bits 2 to 4, kept on soft reset.
// - Bit 0 set on soft reset, kept on pin or watchdog reset, cleared on power-on or low-voltage reset.
module rsc_top (
    input  wire logic        CLK_SYS_I,        // System clock 20 MHz
    input  wire logic        RSTN_I,           // Power-on reset, active low
    input  wire logic        RST_PIN_I,        // External reset pin level
    output logic             RST_PIN_O,        // Reset pin drive value
    output logic             RST_PIN_OE_O,     // Reset pin drive enable
    input  wire logic        LVD_I,            // Low-voltage detect, async
    input  wire logic        WDT_OVF_I,        // Watchdog overflow pulse
    input  wire logic        SUB_RC_READY_I,   // Sub-CR clock ready flag
    input  wire logic        SLOW_MODE_I,      // Subclock, sub-CR or stop mode
    input  wire logic        RAM_BUSY_I,       // RAM access in progress
    input  wire logic        PORT_CFG_I,       // Software configured ports
    output logic             CPU_RST_O,        // Synchronous CPU reset
    output logic             MODE_FETCH_O,     // Mode fetch start pulse
    output logic             PORT_HIZ_O,       // Port pins high impedance
    input  wire logic [3:0]  S_AXI_AWADDR_I,   // Write address
    input  wire logic        S_AXI_AWVALID_I,  // Write address valid
    output logic             S_AXI_AWREADY_O,  // Write address ready
    input  wire logic [31:0] S_AXI_WDATA_I,    // Write data
    input  wire logic [3:0]  S_AXI_WSTRB_I,    // Write strobes
    input  wire logic        S_AXI_WVALID_I,   // Write data valid
    output logic             S_AXI_WREADY_O,   // Write data ready
    output logic [1:0]       S_AXI_BRESP_O,    // Write response
    output logic             S_AXI_BVALID_O,   // Write response valid
    input  wire logic        S_AXI_BREADY_I,   // Write response ready
    input  wire logic [3:0]  S_AXI_ARADDR_I,   // Read address
    input  wire logic        S_AXI_ARVALID_I,  // Read address valid
    output logic             S_AXI_ARREADY_O,  // Read address ready
    output logic [31:0]      S_AXI_RDATA_O,    // Read data
    output logic [1:0]       S_AXI_RRESP_O,    // Read response
    output logic             S_AXI_RVALID_O,   // Read data valid
    input  wire logic        S_AXI_RREADY_I    // Read data ready
);

    logic                pin_meta_r, pin_sync_r, lvd_meta_r, lvd_sync_r;
    logic [7:0]          filt_cnt_r;
    logic                pin_filt_r;
    rsc_pkg::rsc_state_t state_r, state_nxt;
    logic [15:0]         cnt_r, cnt_nxt;
    rsc_pkg::rsc_cause_t cause_r, cause_nxt, evt;
    rsc_pkg::rsc_flags_t flags_r, flags_nxt;
    logic                cpu_rst_nxt;
    logic                soft_req_r, in_en_r, out_en_r;
    logic                pin_arst_n, own_mask_r;

    // ----------------------------------------
    // Pin and level synchronisers
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
            lvd_meta_r <= 1'b0;
            lvd_sync_r <= 1'b0;
        end
        else
        begin
            pin_meta_r <= RST_PIN_I;
            pin_sync_r <= pin_meta_r;
            lvd_meta_r <= LVD_I;
            lvd_sync_r <= lvd_meta_r;
        end
    end

    // Noise filter
    // Level is accepted only after it stays stable for the filter time
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            filt_cnt_r <= 8'h00;
            pin_filt_r <= 1'b1;
        end
        else if (pin_sync_r == pin_filt_r)
            filt_cnt_r <= 8'h00;
        else if (filt_cnt_r == rsc_pkg::FILT_LAST)
        begin
            filt_cnt_r <= 8'h00;
            pin_filt_r <= pin_sync_r;
        end
        else
            filt_cnt_r <= filt_cnt_r + 8'h01;
    end

    // ----------------------------------------
    // Reset sources
    // ----------------------------------------
    // Own drive, and the filter tail after it, is not an external reset
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
            own_mask_r <= 1'b0;
        else
            own_mask_r <= RST_PIN_OE_O || (own_mask_r && !pin_filt_r);
    end

    wire       pin_own   = RST_PIN_OE_O || own_mask_r;

    assign evt.ext = in_en_r && !pin_filt_r && !pin_own;
    assign evt.dog = WDT_OVF_I;
    assign evt.pon = lvd_sync_r;
    assign evt.sw  = soft_req_r;

    wire       run_take  = (state_r == rsc_pkg::ST_RUN) && (|evt);
    wire       lvd_again = evt.pon && (state_r != rsc_pkg::ST_RUN);
    wire       take      = run_take || lvd_again;
    wire       slow_path = cause_r.pon || SLOW_MODE_I || !SUB_RC_READY_I;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb
    begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        cause_nxt   = cause_r;
        cpu_rst_nxt = CPU_RST_O;
        if (lvd_again)
        begin
            state_nxt   = rsc_pkg::ST_SUBW;
            cnt_nxt     = 16'h0000;
            cause_nxt   = rsc_pkg::CAUSE_POR;
            cpu_rst_nxt = 1'b1;
        end
        else
        begin
            unique case (state_r)
                rsc_pkg::ST_RUN:
                begin
                    if (run_take)
                    begin
                        state_nxt = rsc_pkg::ST_HOLD;
                        cause_nxt = evt;
                    end
                end
                rsc_pkg::ST_HOLD:
                begin
                    if (!RAM_BUSY_I)
                    begin
                        cpu_rst_nxt = 1'b1;
                        cnt_nxt     = 16'h0000;
                        state_nxt   = slow_path ? rsc_pkg::ST_SUBW : rsc_pkg::ST_EXTW;
                    end
                end
                rsc_pkg::ST_SUBW:
                begin
                    cnt_nxt = cnt_r + 16'h0001;
                    if (cnt_r == rsc_pkg::SUBCR_LAST)
                        state_nxt = rsc_pkg::ST_EXTW;
                end
                rsc_pkg::ST_EXTW:
                begin
                    cnt_nxt = 16'h0000;
                    if (pin_filt_r || !in_en_r || pin_own)
                        state_nxt = rsc_pkg::ST_MAINW;
                end
                rsc_pkg::ST_MAINW:
                begin
                    cnt_nxt = cnt_r + 16'h0001;
                    if (cnt_r == rsc_pkg::MAINCR_LAST)
                    begin
                        state_nxt   = rsc_pkg::ST_FETCH;
                        cpu_rst_nxt = 1'b0;
                    end
                end
                rsc_pkg::ST_FETCH:
                    state_nxt = rsc_pkg::ST_RUN;
                default:
                    state_nxt = rsc_pkg::ST_RUN;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            state_r      <= rsc_pkg::ST_SUBW;
            cnt_r        <= 16'h0000;
            cause_r      <= rsc_pkg::CAUSE_POR;
            CPU_RST_O    <= 1'b1;
            MODE_FETCH_O <= 1'b0;
        end
        else
        begin
            state_r      <= state_nxt;
            cnt_r        <= cnt_nxt;
            cause_r      <= cause_nxt;
            CPU_RST_O    <= cpu_rst_nxt;
            MODE_FETCH_O <= (state_nxt == rsc_pkg::ST_FETCH);
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            RST_PIN_O    <= 1'b0;
            RST_PIN_OE_O <= 1'b0;
        end
        else
        begin
            RST_PIN_O    <= 1'b0;
            RST_PIN_OE_O <= cpu_rst_nxt && in_en_r && out_en_r && !cause_nxt.ext;
        end
    end

    assign pin_arst_n = RSTN_I && (RST_PIN_I || !in_en_r);

    always_ff @(posedge CLK_SYS_I or negedge pin_arst_n)
    begin
        if (!pin_arst_n)
            PORT_HIZ_O <= 1'b1;
        else if (CPU_RST_O)
            PORT_HIZ_O <= 1'b1;
        else if (PORT_CFG_I)
            PORT_HIZ_O <= 1'b0;
    end

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic [3:0] awaddr_r;
    logic [7:0] wdata_r;
    logic       wstrb0_r;

    wire aw_hs    = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    wire w_hs     = S_AXI_WVALID_I && S_AXI_WREADY_O;
    wire ar_hs    = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    wire wr_go    = !S_AXI_AWREADY_O && !S_AXI_WREADY_O && !S_AXI_BVALID_O;
    wire wr_flags = wr_go && (awaddr_r == rsc_pkg::ADDR_FLAGS);
    wire wr_ctrl  = wr_go && (awaddr_r == rsc_pkg::ADDR_CTRL) && wstrb0_r;
    wire wr_ok    = (awaddr_r == rsc_pkg::ADDR_FLAGS) || (awaddr_r == rsc_pkg::ADDR_CTRL);
    wire rd_flags = ar_hs && (S_AXI_ARADDR_I == rsc_pkg::ADDR_FLAGS);
    wire rd_ctrl  = ar_hs && (S_AXI_ARADDR_I == rsc_pkg::ADDR_CTRL);

    wire [31:0] ctrl_word = {29'h0, out_en_r, in_en_r, 1'b0};
    wire [31:0] flag_word = {27'h0, flags_r};
    wire [31:0] rd_word   = rd_flags ? flag_word : (rd_ctrl ? ctrl_word : 32'h0);

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O  <= 1'b1;
            S_AXI_BVALID_O  <= 1'b0;
            S_AXI_BRESP_O   <= rsc_pkg::RESP_OKAY;
            awaddr_r        <= 4'h0;
            wdata_r         <= 8'h00;
            wstrb0_r        <= 1'b0;
        end
        else
        begin
            if (aw_hs)
            begin
                S_AXI_AWREADY_O <= 1'b0;
                awaddr_r        <= S_AXI_AWADDR_I;
            end
            if (w_hs)
            begin
                S_AXI_WREADY_O <= 1'b0;
                wdata_r        <= S_AXI_WDATA_I[7:0];
                wstrb0_r       <= S_AXI_WSTRB_I[0];
            end
            if (wr_go)
            begin
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O  <= wr_ok ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
            end
            else if (S_AXI_BVALID_O && S_AXI_BREADY_I)
            begin
                S_AXI_BVALID_O  <= 1'b0;
                S_AXI_AWREADY_O <= 1'b1;
                S_AXI_WREADY_O  <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= 32'h0;
            S_AXI_RRESP_O   <= rsc_pkg::RESP_OKAY;
        end
        else if (ar_hs)
        begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b1;
            S_AXI_RDATA_O   <= rd_word;
            S_AXI_RRESP_O   <= (rd_flags || rd_ctrl) ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
        end
        else if (S_AXI_RVALID_O && S_AXI_RREADY_I)
        begin
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_ARREADY_O <= 1'b1;
        end
    end

    // Control register; the soft request bit is a one-cycle strobe
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            soft_req_r <= 1'b0;
            in_en_r    <= rsc_pkg::CTRL_INEN_RST;
            out_en_r   <= rsc_pkg::CTRL_OUTEN_RST;
        end
        else
        begin
            soft_req_r <= wr_ctrl && wdata_r[rsc_pkg::CTRL_SOFT_BIT];
            if (wr_ctrl)
            begin
                in_en_r  <= wdata_r[rsc_pkg::CTRL_INEN_BIT];
                out_en_r <= wdata_r[rsc_pkg::CTRL_OUTEN_BIT];
            end
        end
    end

    // ----------------------------------------
    // Cause flags
    // ----------------------------------------
    // Clear on read or write; a new set wins
    wire        clr  = rd_flags || wr_flags;
    wire        s_ex = take && cause_nxt.ext;
    wire        s_dg = take && cause_nxt.dog;
    wire        s_pn = take && cause_nxt.pon;
    wire        s_sw = take && cause_nxt.sw;

    assign flags_nxt.pin_reset_flag     = s_ex || (flags_r.pin_reset_flag && !clr);
    assign flags_nxt.dog_reset_flag     = s_dg || (flags_r.dog_reset_flag && !clr);
    assign flags_nxt.powerup_reset_flag = s_pn || (flags_r.powerup_reset_flag && !clr);
    assign flags_nxt.hard_reset_flag    = s_ex || s_dg || s_pn || (flags_r.hard_reset_flag && !clr);
    assign flags_nxt.soft_reset_flag    = s_sw || (flags_r.soft_reset_flag && !clr && !s_pn);

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
            flags_r <= rsc_pkg::FLAGS_POR_RST;
        else
            flags_r <= flags_nxt;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);

    property p_fetch_follows_release;
        $fell(CPU_RST_O) |-> MODE_FETCH_O ##1 !MODE_FETCH_O;
    endproperty
    a_fetch_follows_release: assert property (p_fetch_follows_release) else $error("fetch not with release");

    property p_main_before_fetch;
        MODE_FETCH_O |-> $past(state_r) == rsc_pkg::ST_MAINW && $past(cnt_r) == rsc_pkg::MAINCR_LAST;
    endproperty
    a_main_before_fetch: assert property (p_main_before_fetch) else $error("fetch without main wait");

    property p_ram_hold;
        (state_r == rsc_pkg::ST_HOLD && RAM_BUSY_I && !lvd_again) |=> !CPU_RST_O && state_r == rsc_pkg::ST_HOLD;
    endproperty
    a_ram_hold: assert property (p_ram_hold) else $error("reset during RAM access");

    property p_fast_path;
        (state_r == rsc_pkg::ST_HOLD && !RAM_BUSY_I && !slow_path && !lvd_again)
            |=> CPU_RST_O && state_r == rsc_pkg::ST_EXTW;
    endproperty
    a_fast_path: assert property (p_fast_path) else $error("ready sub-CR not skipped");

    property p_slow_path;
        (state_r == rsc_pkg::ST_HOLD && !RAM_BUSY_I && !SUB_RC_READY_I && !lvd_again) |=> state_r == rsc_pkg::ST_SUBW;
    endproperty
    a_slow_path: assert property (p_slow_path) else $error("sub-CR wait skipped");

    property p_lvd_full_wait;
        lvd_again |=> state_r == rsc_pkg::ST_SUBW && cnt_r == 16'h0000 && flags_r.powerup_reset_flag
            && flags_r.hard_reset_flag && !flags_r.soft_reset_flag;
    endproperty
    a_lvd_full_wait: assert property (p_lvd_full_wait) else $error("low voltage not like power-on");

    property p_pin_drive;
        RST_PIN_OE_O |-> CPU_RST_O && !RST_PIN_O && !cause_r.ext && in_en_r && out_en_r;
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin driven wrongly");

    property p_ext_flag;
        (run_take && evt.ext) |=> flags_r.pin_reset_flag && flags_r.hard_reset_flag;
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("pin flag not set");

    property p_read_clear;
        (rd_flags && !take) |=> flags_r == 5'h00 && S_AXI_RDATA_O[4:0] == $past(flags_r);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear flags");

    property p_write_clear;
        (wr_flags && !take && !rd_flags) |=> flags_r == 5'h00;
    endproperty
    a_write_clear: assert property (p_write_clear) else $error("write did not clear flags");

    property p_upper_zero;
        (S_AXI_RVALID_O && $past(rd_flags)) |-> S_AXI_RDATA_O[31:5] == 27'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper flag bits not zero");

    c_fetch: cover property ($fell(CPU_RST_O));
    c_ext_reset: cover property (run_take && evt.ext);
    c_soft_reset: cover property (run_take && evt.sw ##[1:500] MODE_FETCH_O);

endmodule : rsc_top
`default_nettype wire

// [sim/rsc_pin_drv.sv]
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_drv (
    input  wire logic       clk_i,   // System clock
    input  wire logic       go_i,    // Start a low pulse
    input  wire logic [7:0] len_i,   // Pulse length in cycles
    output logic            low_o    // Pulls the pin low
);
    logic [7:0] cnt_r = 8'h00;

    always_ff @(posedge clk_i)
    begin
        if (go_i)
            cnt_r <= len_i;
        else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
    end
    assign low_o = (cnt_r != 8'h00);
endmodule : rsc_pin_drv
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0, rstn = 1'b0, lvd = 1'b0, wdt = 1'b0, scr = 1'b1, slow = 1'b0;
    logic        busy = 1'b0, pcfg = 1'b0, go = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [3:0]  awa = 4'h0, ara = 4'h0;
    logic [31:0] wd = 32'h0, d;
    logic [1:0]  r;
    logic [7:0]  len = 8'h00;
    wire logic   pin_o, oe, awr, wr, bv, arr, rv, crst, fetch, hiz, low;
    wire logic [1:0]  br, rresp;
    wire logic [31:0] rd;
    wire logic   pin = oe ? pin_o : ~low;
    int          num_errors = 0, checked = 0, n;

    always #25 clk = ~clk;

    rsc_pin_drv u_pin (.clk_i(clk), .go_i(go), .len_i(len), .low_o(low));
    rsc_top u_dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .RST_PIN_I(pin), .RST_PIN_O(pin_o), .RST_PIN_OE_O(oe),
        .LVD_I(lvd), .WDT_OVF_I(wdt), .SUB_RC_READY_I(scr), .SLOW_MODE_I(slow), .RAM_BUSY_I(busy),
        .PORT_CFG_I(pcfg), .CPU_RST_O(crst), .MODE_FETCH_O(fetch), .PORT_HIZ_O(hiz),
        .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
        .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(br),
        .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
        .S_AXI_RREADY_I(rry));

    // ----------------
    // Shared tasks
    // ----------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic dur(input int k, input int lo);
        chk(32'(k >= lo && k < lo + 30), 32'h1);
    endtask : dur

    task automatic axw(input logic [3:0] a, input logic [31:0] v);
        bit pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        awa <= a;
        wd  <= v;
        awv <= 1'b1;
        wv  <= 1'b1;
        while (pa || pw)
        begin
            @(posedge clk);
            if (pa && awr === 1'b1)
            begin
                pa = 1'b0;
                awv <= 1'b0;
            end
            if (pw && wr === 1'b1)
            begin
                pw = 1'b0;
                wv <= 1'b0;
            end
        end
        bry <= 1'b1;
        do @(posedge clk); while (bv !== 1'b1);
        r = br;
        bry <= 1'b0;
    endtask : axw

    task automatic axr(input logic [3:0] a);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        rry <= 1'b1;
        do @(posedge clk); while (rv !== 1'b1);
        d = rd;
        r = rresp;
        rry <= 1'b0;
    endtask : axr

    task automatic pulse_wdt;
        @(posedge clk);
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
    endtask : pulse_wdt

    task automatic pin_pulse(input logic [7:0] k);
        @(posedge clk);
        go  <= 1'b1;
        len <= k;
        @(posedge clk);
        go  <= 1'b0;
    endtask : pin_pulse

    task automatic wait_fetch;
        n = 0;
        while (fetch !== 1'b1)
        begin
            @(posedge clk);
            if (crst === 1'b1) n++;
        end
        chk(crst, 1'b0);
        pcfg <= 1'b1;
        @(posedge clk);
        pcfg <= 1'b0;
        repeat (2) @(posedge clk);
        chk(hiz, 1'b0);
    endtask : wait_fetch

    // ----------------
    // Scenarios
    // ----------------
    task automatic t_por;
        wait_fetch();
        dur(n, rsc_pkg::SUBCR_CYC + rsc_pkg::MAINCR_CYC);
        axr(rsc_pkg::ADDR_FLAGS);
        chk(d, 32'h06);
        axr(rsc_pkg::ADDR_FLAGS);
        chk(d, 32'h00);
        axr(4'h8);
        chk({d[29:0], r}, {30'h0, rsc_pkg::RESP_SLVERR});
    endtask : t_por

    task automatic t_soft;
        axw(rsc_pkg::ADDR_CTRL, 32'h7);
        do @(posedge clk); while (crst !== 1'b1);
        chk(oe, 1'b1);
        wait_fetch();
        dur(n, rsc_pkg::MAINCR_CYC);
        chk(oe, 1'b0);
    endtask : t_soft

    task automatic t_dog_slow;
        t_soft();
        axr(rsc_pkg::ADDR_FLAGS);
        chk(d, 32'h01);
        scr <= 1'b0;
        pulse_wdt();
        wait_fetch();
        dur(n, rsc_pkg::SUBCR_CYC + rsc_pkg::MAINCR_CYC);
        scr <= 1'b1;
        axr(rsc_pkg::ADDR_FLAGS);
        chk(d, 32'h0A);
        slow <= 1'b1;
        pulse_wdt();
        wait_fetch();
        dur(n, rsc_pkg::SUBCR_CYC + rsc_pkg::MAINCR_CYC);
        slow <= 1'b0;
        axr(rsc_pkg::ADDR_FLAGS);
        chk(d, 32'h0A);
    endtask : t_dog_slow

    task automatic t_ram;
        busy <= 1'b1;
        pulse_wdt();
        repeat (6) @(posedge clk);
        chk(crst, 1'b0);
        busy <= 1'b0;
        repeat (3) @(posedge clk);
        chk(crst, 1'b1);
        wait_fetch();
        axw(rsc_pkg::ADDR_FLAGS, 32'hFF);
        chk(r, rsc_pkg::RESP_OKAY);
        axr(rsc_pkg::ADDR_FLAGS);
        chk(d, 32'h00);
    endtask : t_ram

    task automatic t_pin;
        pin_pulse(8'd20);
        #1;
        chk(hiz, 1'b1);
        repeat (10) @(posedge clk);
        chk({crst, oe}, 2'b10);
        wait_fetch();
        axr(rsc_pkg::ADDR_FLAGS);
        chk(d, 32'h12);
        pin_pulse(8'd2);
        repeat (12) @(posedge clk);
        chk(crst, 1'b0);
    endtask : t_pin

    // Soft then pin reset leave 0x13; low voltage must keep bit 4 and clear bit 0
    task automatic t_lvd;
        t_soft();
        pin_pulse(8'd20);
        wait_fetch();
        @(posedge clk);
        lvd <= 1'b1;
        repeat (3) @(posedge clk);
        lvd <= 1'b0;
        wait_fetch();
        dur(n, rsc_pkg::SUBCR_CYC + rsc_pkg::MAINCR_CYC);
        axr(rsc_pkg::ADDR_FLAGS);
        chk(d, 32'h16);
    endtask : t_lvd

    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (30000) @(posedge clk);
        num_errors++;
        final_report();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_por();
        t_dog_slow();
        t_ram();
        t_pin();
        t_lvd();
        final_report();
    end
endmodule : tb_top
`default_nettype wire
